// ===== hw/vol_ramp_defines.svh
// register indices, field positions, reset values and zero-run limits
`ifndef VOL_RAMP_DEFINES_SVH
`define VOL_RAMP_DEFINES_SVH
// register indices; the byte address is four times the index
`define VR_IDX_EMERG 10'h04F
`define VR_IDX_ZMCTL 10'h050
`define VR_IDX_ZMTIME 10'h051
`define VR_IDX_RAMPCFG 10'h060
`define VR_IDX_STATUS 10'h061
// reset values
`define VR_RST_EMERG 8'h30
`define VR_RST_ZMCTL 8'h07
`define VR_RST_ZMTIME 8'h00
`define VR_RST_RAMPCFG 32'h0000_0330
`define VR_RST_VOL 8'h30
// emergency ramp control fields
`define VR_E_RATE 7:6
`define VR_E_STEP 5:4
// zero mute control fields
`define VR_Z_LINK 2
`define VR_Z_RIGHT_EN 1
`define VR_Z_LEFT_EN 0
// zero mute time fields
`define VR_T_LEFT 6:4
`define VR_T_RIGHT 2:0
// ramp configuration fields
`define VR_C_VOL 7:0
`define VR_C_STEP 9:8
`define VR_C_RATE 11:10
`define VR_C_SOFTMUTE 12
`define VR_C_DELAY 23:16
// rate code that forces an instant mute
`define VR_RATE_INSTANT 2'h3
// volume code meaning mute
`define VR_VOL_MUTE 8'hFF
// zero-run limits in frames, figured at 96 kHz
`define VR_ZT_000 19'h0_0450
`define VR_ZT_001 19'h0_13E0
`define VR_ZT_010 19'h0_27F0
`define VR_ZT_011 19'h0_4FE0
`define VR_ZT_100 19'h0_C8A0
`define VR_ZT_101 19'h1_8F60
`define VR_ZT_110 19'h3_E760
`define VR_ZT_111 19'h7_CEC0
`define VR_ZT_SAT 19'h7_FFFF
`endif

// ===== hw/vol_ramp_pkg.sv
// types shared by the volume ramp and zero mute block
package vol_ramp_pkg;
  typedef enum logic [1:0] {
    AM_IDLE = 2'b00,
    AM_WAIT = 2'b01,
    AM_MUTED = 2'b10
  } amute_state_t;
endpackage : vol_ramp_pkg

// ===== hw/volume_emergency_ramp_automute.sv
// volume ramp, emergency ramp-down and zero-sample auto mute with axi4-lite registers
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "vol_ramp_defines.svh"

module volume_emergency_ramp_automute
  import vol_ramp_pkg::*;
#(
  parameter int SAMPLE_W = 24,
  parameter int ADDR_W = 12,
  parameter int ZERO_SHIFT = 0
)(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // emergency pins, asynchronous
  input wire logic i_clk_error,
  input wire logic i_power_fail,
  // sample stream, one strobe per frame
  input wire logic i_frame_valid,
  input wire logic [SAMPLE_W-1:0] i_left_sample,
  input wire logic [SAMPLE_W-1:0] i_right_sample,
  // volume and mute outputs
  output logic [7:0] o_left_volume,
  output logic [7:0] o_right_volume,
  output logic o_left_automute,
  output logic o_right_automute,
  output logic o_analog_mute,
  output logic o_emergency
);

  initial
  begin
    if (SAMPLE_W < 1 || ADDR_W < 12 || ZERO_SHIFT < 0 || ZERO_SHIFT > 18)
      $error("volume_emergency_ramp_automute: unsupported parameter");
  end

  // registers
  logic [7:0] emerg_reg;
  logic [7:0] zmctl_reg;
  logic [7:0] zmtime_reg;
  logic [31:0] rampcfg_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] err_sync_reg;
  logic [1:0] pf_sync_reg;
  logic emerg_active_reg;
  logic [1:0] div_reg;
  logic [1:0][18:0] zcnt_reg;
  logic [1:0] am_reg;
  logic [1:0][7:0] vol_reg;
  amute_state_t am_state_reg;
  amute_state_t am_state_next;
  logic [7:0] delay_cnt_reg;
  logic analog_mute_reg;

  // write address decode on the held address
  wire [9:0] wr_idx = awaddr_reg[11:2];
  wire wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  wire wr_emerg = wr_fire && (wr_idx == `VR_IDX_EMERG);
  wire wr_zmctl = wr_fire && (wr_idx == `VR_IDX_ZMCTL);
  wire wr_zmtime = wr_fire && (wr_idx == `VR_IDX_ZMTIME);
  wire wr_rampcfg = wr_fire && (wr_idx == `VR_IDX_RAMPCFG);
  wire wr_status = wr_fire && (wr_idx == `VR_IDX_STATUS);
  wire wr_hit = wr_emerg || wr_zmctl || wr_zmtime || wr_rampcfg || wr_status;
  wire [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0] cfg_merge = (rampcfg_reg & ~strb_mask) | (wdata_reg & strb_mask);

  // read decode; status is the block's live state
  wire [9:0] rd_idx = i_araddr[11:2];
  wire ar_take = i_arvalid && arready_reg;
  wire [31:0] status_word = {12'h000, emerg_active_reg, analog_mute_reg, am_reg, vol_reg[1], vol_reg[0]};
  wire rd_hit = (rd_idx == `VR_IDX_EMERG) || (rd_idx == `VR_IDX_ZMCTL) || (rd_idx == `VR_IDX_ZMTIME)
    || (rd_idx == `VR_IDX_RAMPCFG) || (rd_idx == `VR_IDX_STATUS);
  wire [31:0] rd_word =
    (rd_idx == `VR_IDX_EMERG) ? {24'h00_0000, emerg_reg} :
    (rd_idx == `VR_IDX_ZMCTL) ? {24'h00_0000, zmctl_reg} :
    (rd_idx == `VR_IDX_ZMTIME) ? {24'h00_0000, zmtime_reg} :
    (rd_idx == `VR_IDX_RAMPCFG) ? rampcfg_reg :
    (rd_idx == `VR_IDX_STATUS) ? status_word : 32'h0000_0000;

  // write channel handshake: address and data taken in either order
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (i_awvalid && awready_reg)
      begin
        awready_reg <= 1'b0;
        awaddr_reg <= i_awaddr;
      end
      if (i_wvalid && wready_reg)
      begin
        wready_reg <= 1'b0;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? 2'h0 : 2'h2; // unmapped answers slverr
      end
      if (bvalid_reg && i_bready)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // configuration registers; status writes are accepted and dropped
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      emerg_reg <= `VR_RST_EMERG;
      zmctl_reg <= `VR_RST_ZMCTL;
      zmtime_reg <= `VR_RST_ZMTIME;
      rampcfg_reg <= `VR_RST_RAMPCFG;
    end
    else
    begin
      if (wr_emerg && wstrb_reg[0])
        emerg_reg <= wdata_reg[7:0];
      if (wr_zmctl && wstrb_reg[0])
        zmctl_reg <= wdata_reg[7:0];
      if (wr_zmtime && wstrb_reg[0])
        zmtime_reg <= wdata_reg[7:0];
      if (wr_rampcfg)
        rampcfg_reg <= cfg_merge;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end
    else if (ar_take)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (rvalid_reg && i_rready)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // two-flop synchronisers for the emergency pins
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      err_sync_reg <= 2'h0;
      pf_sync_reg <= 2'h0;
      emerg_active_reg <= 1'b0;
    end
    else
    begin
      err_sync_reg <= {err_sync_reg[0], i_clk_error};
      pf_sync_reg <= {pf_sync_reg[0], i_power_fail};
      emerg_active_reg <= err_sync_reg[1] || pf_sync_reg[1];
    end
  end

  wire [1:0] ramp_rate = emerg_active_reg ? emerg_reg[`VR_E_RATE] : rampcfg_reg[`VR_C_RATE];
  wire [1:0] ramp_step = emerg_active_reg ? emerg_reg[`VR_E_STEP] : rampcfg_reg[`VR_C_STEP];
  // half-dB codes per update: 8, 4, 2, 1
  wire [7:0] step_amt = 8'h08 >> ramp_step;
  // update every 1, 2 or 4 frames
  wire ramp_tick = i_frame_valid && ((ramp_rate == 2'h0) || (ramp_rate == 2'h1 && div_reg[0])
    || (ramp_rate == 2'h2 && div_reg == 2'h3));

  // frame divider, free running so updates stay evenly spaced
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_reg <= 2'h0;
    else if (i_frame_valid)
      div_reg <= div_reg + 2'h1;
  end

  // zero-run limit per time code, shortenable for simulation
  function automatic logic [18:0] zero_limit(input logic [2:0] code);
    logic [18:0] lim;
    lim = `VR_ZT_000;
    unique case (code)
      3'h0: lim = `VR_ZT_000;
      3'h1: lim = `VR_ZT_001;
      3'h2: lim = `VR_ZT_010;
      3'h3: lim = `VR_ZT_011;
      3'h4: lim = `VR_ZT_100;
      3'h5: lim = `VR_ZT_101;
      3'h6: lim = `VR_ZT_110;
      3'h7: lim = `VR_ZT_111;
    endcase
    zero_limit = lim >> ZERO_SHIFT;
  endfunction : zero_limit

  // per-channel limits; index 0 left, 1 right
  wire [1:0][18:0] zlimit = {zero_limit(zmtime_reg[`VR_T_RIGHT]), zero_limit(zmtime_reg[`VR_T_LEFT])};
  wire [1:0][SAMPLE_W-1:0] samples = {i_right_sample, i_left_sample};
  wire [1:0] ch_en = {zmctl_reg[`VR_Z_RIGHT_EN], zmctl_reg[`VR_Z_LEFT_EN]};
  wire [1:0] qual;
  wire [1:0] am_next;
  wire soft_mute = rampcfg_reg[`VR_C_SOFTMUTE];

  assign am_next = zmctl_reg[`VR_Z_LINK] ? {2{&qual}} : qual;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      // qualify only when the channel is enabled
      assign qual[ch] = ch_en[ch] && (zcnt_reg[ch] >= zlimit[ch]);

      // zero-run counter, saturating so long silence never wraps
      always_ff @(posedge i_ref_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          zcnt_reg[ch] <= 19'h0_0000;
        else if (i_frame_valid)
          zcnt_reg[ch] <= (samples[ch] != '0) ? 19'h0_0000 :
            (zcnt_reg[ch] == `VR_ZT_SAT) ? zcnt_reg[ch] : zcnt_reg[ch] + 19'h0_0001;
      end

      // channel volume: ramp toward mute, restore the target at once
      always_ff @(posedge i_ref_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          am_reg[ch] <= 1'b0;
          vol_reg[ch] <= `VR_RST_VOL;
        end
        else
        begin
          am_reg[ch] <= am_next[ch];
          if (emerg_active_reg || soft_mute || am_reg[ch])
          begin
            if (ramp_rate == `VR_RATE_INSTANT)
              vol_reg[ch] <= `VR_VOL_MUTE;
            else if (ramp_tick)
              vol_reg[ch] <= (vol_reg[ch] > (`VR_VOL_MUTE - step_amt)) ? `VR_VOL_MUTE : vol_reg[ch] + step_amt;
          end
          else
            vol_reg[ch] <= rampcfg_reg[`VR_C_VOL];
        end
      end
    end
  endgenerate

  // analog mute follows full digital mute after the frame delay
  wire both_muted = (vol_reg[0] == `VR_VOL_MUTE) && (vol_reg[1] == `VR_VOL_MUTE);
  wire [7:0] amute_delay = rampcfg_reg[`VR_C_DELAY];
  wire delay_done = i_frame_valid && (delay_cnt_reg == amute_delay - 8'h01);

  always_comb
  begin
    am_state_next = am_state_reg;
    unique case (am_state_reg)
      AM_IDLE:
        if (both_muted)
          am_state_next = (amute_delay == 8'h00) ? AM_MUTED : AM_WAIT;
      AM_WAIT:
        if (!both_muted)
          am_state_next = AM_IDLE;
        else if (delay_done)
          am_state_next = AM_MUTED;
      AM_MUTED:
        if (!both_muted)
          am_state_next = AM_IDLE;
      default:
        am_state_next = AM_IDLE;
    endcase
  end

  // delay counter counts frames only while waiting
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      am_state_reg <= AM_IDLE;
      delay_cnt_reg <= 8'h00;
      analog_mute_reg <= 1'b0;
    end
    else
    begin
      am_state_reg <= am_state_next;
      analog_mute_reg <= (am_state_next == AM_MUTED);
      if (am_state_reg != AM_WAIT)
        delay_cnt_reg <= 8'h00;
      else if (i_frame_valid)
        delay_cnt_reg <= delay_cnt_reg + 8'h01;
    end
  end

  // outputs straight from flops
  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_left_volume = vol_reg[0];
  assign o_right_volume = vol_reg[1];
  assign o_left_automute = am_reg[0];
  assign o_right_automute = am_reg[1];
  assign o_analog_mute = analog_mute_reg;
  assign o_emergency = emerg_active_reg;

endmodule : volume_emergency_ramp_automute

// ===== testbench/vol_ramp_assertions.sv
// concurrent checks on the volume ramp and zero mute ports
`timescale 1ns/1ps
module vol_ramp_assertions #(
  parameter int SAMPLE_W = 24
)(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  // emergency, samples and mutes
  input wire logic i_clk_error,
  input wire logic i_power_fail,
  input wire logic i_frame_valid,
  input wire logic [SAMPLE_W-1:0] i_left_sample,
  input wire logic [7:0] o_left_volume,
  input wire logic [7:0] o_right_volume,
  input wire logic o_left_automute,
  input wire logic o_analog_mute,
  input wire logic o_emergency
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // pin held across the two-flop synchroniser
  sequence s_pin_held;
    (i_clk_error || i_power_fail) [*3];
  endsequence
  // write taken: both readies drop, answer follows one cycle later
  sequence s_write_answer;
    !o_awready && !o_wready ##1 o_bvalid;
  endsequence
  a_emerg_sync: assert property (s_pin_held |=> o_emergency)
    else $error("emergency not raised");
  a_emerg_ramp: assert property (o_emergency && $past(o_emergency) |-> o_left_volume >= $past(o_left_volume))
    else $error("volume rose during emergency");
  a_zero_rise: assert property ($rose(o_left_automute) |-> $past(i_frame_valid && i_left_sample == '0, 2))
    else $error("left mute without zero frame");
  a_zero_clear: assert property (i_frame_valid && i_left_sample != '0 |-> ##2 !o_left_automute)
    else $error("left mute kept after nonzero");
  a_analog_late: assert property ($rose(o_analog_mute) |-> $past(o_left_volume == 8'hFF && o_right_volume == 8'hFF))
    else $error("analog mute before digital mute");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> s_write_answer)
    else $error("write answer missing");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read answer missing");
  a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid)
    else $error("read response dropped");
endmodule : vol_ramp_assertions

bind volume_emergency_ramp_automute vol_ramp_assertions #(.SAMPLE_W(SAMPLE_W)) chk_u (.*);

// ===== testbench/audio_frame_source.sv
// upstream sample source: one frame strobe every PERIOD clocks
`timescale 1ns/1ps
module audio_frame_source #(
  parameter int SAMPLE_W = 24,
  parameter int PERIOD = 8
)(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // zero requests
  input wire logic i_zero_left,
  input wire logic i_zero_right,
  // sample stream
  output logic o_frame_valid,
  output logic [SAMPLE_W-1:0] o_left_sample,
  output logic [SAMPLE_W-1:0] o_right_sample
);
  int cnt;
  logic last;
  assign last = cnt == PERIOD - 1;
  // noise between strobes so stale data never passes as a sample
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= 0;
      o_frame_valid <= 1'b0;
      o_left_sample <= '1;
      o_right_sample <= '1;
    end
    else
    begin
      cnt <= last ? 0 : cnt + 1;
      o_frame_valid <= last;
      o_left_sample <= (last && i_zero_left) ? '0 : SAMPLE_W'($urandom | 1);
      o_right_sample <= (last && i_zero_right) ? '0 : SAMPLE_W'($urandom | 2);
    end
  end
endmodule : audio_frame_source

// ===== testbench/volume_emergency_ramp_automute_test.sv
// self-checking bench for the volume ramp and zero mute block
`timescale 1ns/1ps
module volume_emergency_ramp_automute_test;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, clk_err, pwr_fail, zl, zr, fv;
  logic awready, wready, bvalid, arready, rvalid, lam, ram, amute, emerg;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] lvol, rvol, tv;
  logic [3:0] strb;
  logic [23:0] ls, rs;
  logic [2:0] ct [6] = '{3, 3, 7, 7, 1, 2};
  logic [1:0] zt [6] = '{2, 1, 3, 2, 3, 3};
  int errors, checked, seed;

  volume_emergency_ramp_automute #(.ZERO_SHIFT(8)) dut_u (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_awprot(3'h0), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(strb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .i_arprot(3'h0), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_clk_error(clk_err), .i_power_fail(pwr_fail), .i_frame_valid(fv),
    .i_left_sample(ls), .i_right_sample(rs), .o_left_volume(lvol), .o_right_volume(rvol),
    .o_left_automute(lam), .o_right_automute(ram), .o_analog_mute(amute), .o_emergency(emerg));
  audio_frame_source src_u (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_zero_left(zl), .i_zero_right(zr), .o_frame_valid(fv), .o_left_sample(ls), .o_right_sample(rs));

  task stop_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // every handshake and strobe wait goes through here so a hang ends the run
  task tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 400)
    begin
      errors++;
      stop_test();
    end
  endtask : tick
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw && w))
    begin
      tick(n);
      aw = aw || awready;
      w = w || wready;
      awvalid <= !aw;
      wvalid <= !w;
    end
    // random back-pressure on the response
    repeat ($urandom_range(2)) tick(n);
    bready <= 1;
    do tick(n); while (!bvalid);
    chk("bresp", bresp, er);
    bready <= 0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1;
    do tick(n); while (!arready);
    arvalid <= 0;
    repeat ($urandom_range(2)) tick(n);
    rready <= 1;
    do tick(n); while (!rvalid);
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
    rready <= 0;
  endtask : rd
  // waits k strobes, then lets their effect settle
  task frames(input int k);
    int n;
    n = 0;
    repeat (k) do tick(n); while (!fv);
    repeat (2) @(posedge clk);
  endtask : frames
  function automatic int lim(input logic [2:0] c);
    int t[8] = '{1104, 5088, 10224, 20448, 51360, 102240, 255840, 511680};
    return t[c] >> 8;
  endfunction : lim
  function automatic logic [7:0] ev(input logic [3:0] c);
    if (c[3:2] == 2'h3) return 8'hFF;
    return 8'h30 + 8'((8 >> c[3:2]) * (8 >> c[1:0]));
  endfunction : ev
  // one zero run with mute control and time codes given
  task zrun(input logic [2:0] ctl, input logic [2:0] tl, input logic [2:0] tr, input logic [1:0] z);
    logic ql, qr;
    zl <= 0;
    zr <= 0;
    frames(1);
    wr(12'h140, {29'h0, ctl}, 2'h0);
    wr(12'h144, {25'h0, tl, 1'b0, tr}, 2'h0);
    zl <= z[1];
    zr <= z[0];
    // the source samples the zero request one edge before its strobe
    @(posedge clk);
    for (int n = 1; n <= lim(tl) + lim(tr) + 1; n++)
    begin
      frames(1);
      ql = ctl[0] && z[1] && n >= lim(tl);
      qr = ctl[1] && z[0] && n >= lim(tr);
      if (ctl[2]) ql = ql && qr;
      if (ctl[2]) qr = ql;
      chk("left_automute", lam, ql);
      chk("right_automute", ram, qr);
    end
    zl <= 0;
    zr <= 0;
    frames(1);
  endtask : zrun

  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, clk_err, pwr_fail, zl, zr} = '0;
    {awaddr, araddr, wdata, errors, checked} = '0;
    strb = 4'hF;
    seed = $urandom(67);
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(12'h13C, 32'h0000_0030, 2'h0);
    rd(12'h140, 32'h0000_0007, 2'h0);
    rd(12'h144, 32'h0000_0000, 2'h0);
    rd(12'h180, 32'h0000_0330, 2'h0);
    wr(12'h184, 32'hFFFF_FFFF, 2'h0);
    rd(12'h184, 32'h0000_3030, 2'h0);
    rd(12'h000, 32'h0000_0000, 2'h2);
    wr(12'h000, 32'h0000_0001, 2'h2);
    tv = 8'($urandom);
    wr(12'h144, {24'h0, tv}, 2'h0);
    rd(12'h144, {24'h0, tv}, 2'h0);
    for (int i = 0; i < 6; i++)
      zrun(ct[i], 3'($urandom_range(2)), 3'($urandom_range(2)), zt[i]);
    // every emergency rate and step pair, pins alternating
    for (int c = 0; c < 16; c++)
    begin
      wr(12'h13C, {24'h0, 4'(c), 4'h0}, 2'h0);
      frames(1);
      if (c % 2 == 1) clk_err <= 1;
      else pwr_fail <= 1;
      frames(8);
      chk("emergency", emerg, 1);
      chk("left_volume", lvol, ev(4'(c)));
      chk("right_volume", rvol, ev(4'(c)));
      chk("analog_mute", amute, c >= 12);
      clk_err <= 0;
      pwr_fail <= 0;
      repeat (6) @(posedge clk);
      chk("left_volume", lvol, 8'h30);
    end
    // lane 0 off: the 8-bit register keeps its value
    strb <= 4'h2;
    wr(12'h13C, 32'h0000_0000, 2'h0);
    rd(12'h13C, 32'h0000_00F0, 2'h0);
    // soft mute keeps the normal settings, not the instant emergency code; only lane 1 lands
    frames(1);
    wr(12'h180, 32'hFFFF_13FF, 2'h0);
    strb <= 4'hF;
    frames(8);
    chk("left_volume", lvol, 8'h38);
    rd(12'h180, 32'h0000_1330, 2'h0);
    // a delay of three frames between full digital mute and analog mute
    wr(12'h180, 32'h0003_0330, 2'h0);
    frames(1);
    clk_err <= 1;
    frames(2);
    chk("analog_mute", amute, 0);
    frames(1);
    chk("analog_mute", amute, 1);
    clk_err <= 0;
    stop_test();
  end
endmodule : volume_emergency_ramp_automute_test
